// ### inc/i2c_ack_pkg.sv
// constants and types shared by the i2c target acknowledge logic
// assumes a system clock much faster than scl (10 MHz against <= 1.25 MHz scl)
package i2c_ack_pkg;

    // ------------------------------------------------------------
    // byte framing
    // ------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_RST   = 4'h0;
    localparam logic [7:0] BYTE_RST  = 8'h00;

    // ------------------------------------------------------------
    // line levels
    // ------------------------------------------------------------
    localparam logic LINE_IDLE = 1'b1;
    localparam logic SDA_LOW   = 1'b0;

    // ------------------------------------------------------------
    // protocol states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        st_idle,
        st_arm,
        st_data,
        st_ack,
        st_done
    } state_t;

endpackage

// ### design/line_sync.sv
// two-flop synchroniser for a vector of asynchronous line inputs
// assumes each bit is an independent level; no bus coherence is implied
`timescale 1ns/1ps
module line_sync #(
    parameter int unsigned WIDTH   = 2,
    parameter logic        RST_VAL = 1'b1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // ------------------------------------------------------------
    // first stage feeds only the second stage
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= {WIDTH{RST_VAL}};
            sync_out <= {WIDTH{RST_VAL}};
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// ### design/i2c_target_ack.sv
// i2c target byte engine with acknowledge handling, both directions
// assumes scl/sda pins arrive asynchronously; address matching is done upstream
`timescale 1ns/1ps

module i2c_target_ack
    import i2c_ack_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       tx_mode,
    input  wire logic       ack_enable,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_byte,
    output logic            rx_valid,
    output logic            tx_next,
    output logic            master_nack,
    output logic            start_seen,
    output logic            stop_seen,
    output logic            bus_busy
);

    // ------------------------------------------------------------
    // pin synchronisation and bus events
    // ------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic scl_q;
    logic sda_q;

    line_sync #(.WIDTH(2), .RST_VAL(LINE_IDLE)) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({scl_in, sda_in}),
        .sync_out ({scl_s, sda_s})
    );

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

    // ------------------------------------------------------------
    // protocol state
    // ------------------------------------------------------------
    state_t     state;
    state_t     next_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] next_rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] next_tx_shift;
    logic       tx_role;
    logic       next_tx_role;
    logic       acked;
    logic       next_acked;
    logic       next_sda_oe;
    logic [7:0] next_rx_byte;
    logic       next_rx_valid;
    logic       next_tx_next;
    logic       next_master_nack;
    logic       next_start_seen;
    logic       next_stop_seen;
    logic       next_bus_busy;
    logic [3:0] tx_idx;

    always_comb begin
        tx_idx           = BYTE_BITS - 4'h1 - bit_cnt;
        next_state       = state;
        next_bit_cnt     = bit_cnt;
        next_rx_shift    = rx_shift;
        next_tx_shift    = tx_shift;
        next_tx_role     = tx_role;
        next_acked       = acked;
        next_sda_oe      = sda_oe;
        next_rx_byte     = rx_byte;
        next_rx_valid    = 1'b0;
        next_tx_next     = 1'b0;
        next_master_nack = 1'b0;
        next_start_seen  = 1'b0;
        next_stop_seen   = 1'b0;
        // drive changes happen only on scl falling edges
        unique case (state)
            st_idle: begin
                next_sda_oe = 1'b0;
            end
            st_arm: begin
                if (scl_fall) begin
                    next_state    = st_data;
                    next_bit_cnt  = CNT_RST;
                    next_tx_role  = tx_mode;
                    next_tx_shift = tx_byte;
                    next_sda_oe   = tx_mode & ~tx_byte[7];
                end
            end
            st_data: begin
                if (scl_rise) begin
                    next_rx_shift = {rx_shift[6:0], sda_s};
                    next_bit_cnt  = bit_cnt + 4'h1;
                end else if (scl_fall) begin
                    if (bit_cnt == BYTE_BITS) begin
                        next_state = st_ack;
                        if (tx_role) begin
                            next_sda_oe = 1'b0;
                        end else begin
                            next_sda_oe   = ack_enable;
                            next_rx_byte  = rx_shift;
                            next_rx_valid = 1'b1;
                        end
                    end else if (tx_role) begin
                        next_sda_oe = ~tx_shift[tx_idx[2:0]];
                    end
                end
            end
            st_ack: begin
                if (scl_rise) begin
                    next_acked = ~sda_s;
                end else if (scl_fall) begin
                    next_bit_cnt = CNT_RST;
                    if (tx_role && acked) begin
                        next_state    = st_data;
                        next_tx_shift = tx_byte;
                        next_sda_oe   = ~tx_byte[7];
                        next_tx_next  = 1'b1;
                    end else if (tx_role) begin
                        next_state       = st_done;
                        next_sda_oe      = 1'b0;
                        next_master_nack = 1'b1;
                    end else begin
                        next_state  = st_data;
                        next_sda_oe = 1'b0;
                    end
                end
            end
            st_done: begin
                next_sda_oe = 1'b0;
            end
        endcase
        // bus conditions override any byte in progress
        if (stop_det) begin
            next_state     = st_idle;
            next_sda_oe    = 1'b0;
            next_stop_seen = 1'b1;
        end else if (start_det) begin
            next_state      = st_arm;
            next_sda_oe     = 1'b0;
            next_start_seen = 1'b1;
        end
        next_bus_busy = (next_state != st_idle);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q       <= LINE_IDLE;
            sda_q       <= LINE_IDLE;
            state       <= st_idle;
            bit_cnt     <= CNT_RST;
            rx_shift    <= BYTE_RST;
            tx_shift    <= BYTE_RST;
            tx_role     <= 1'b0;
            acked       <= 1'b0;
            sda_oe      <= 1'b0;
            sda_out     <= SDA_LOW;
            rx_byte     <= BYTE_RST;
            rx_valid    <= 1'b0;
            tx_next     <= 1'b0;
            master_nack <= 1'b0;
            start_seen  <= 1'b0;
            stop_seen   <= 1'b0;
            bus_busy    <= 1'b0;
        end else begin
            scl_q       <= scl_s;
            sda_q       <= sda_s;
            state       <= next_state;
            bit_cnt     <= next_bit_cnt;
            rx_shift    <= next_rx_shift;
            tx_shift    <= next_tx_shift;
            tx_role     <= next_tx_role;
            acked       <= next_acked;
            sda_oe      <= next_sda_oe;
            sda_out     <= SDA_LOW;   // open drain: only ever pulls low
            rx_byte     <= next_rx_byte;
            rx_valid    <= next_rx_valid;
            tx_next     <= next_tx_next;
            master_nack <= next_master_nack;
            start_seen  <= next_start_seen;
            stop_seen   <= next_stop_seen;
            bus_busy    <= next_bus_busy;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence fall_ending_ack;
        state == st_ack && scl_fall && !stop_det && !start_det;
    endsequence

    sequence byte_complete;
        state == st_data && scl_fall && bit_cnt == BYTE_BITS && !stop_det && !start_det;
    endsequence

    byte_to_ack_a: assert property (byte_complete |=> state == st_ack)
        else $error("eighth bit did not open the acknowledge slot");
    rx_ack_drive_a: assert property (byte_complete and !tx_role && ack_enable
        |=> sda_oe && rx_valid)
        else $error("received byte not acknowledged");
    tx_release_a: assert property (state == st_ack && tx_role |-> !sda_oe)
        else $error("transmitter drove sda in acknowledge slot");
    scl_high_stable_a: assert property (scl_s && scl_q |=> $stable(sda_oe))
        else $error("sda drive changed while scl high");
    ack_held_a: assert property (state == st_ack && !tx_role && sda_oe && scl_rise
        |-> sda_oe [*2])
        else $error("acknowledge not held through scl high");
    ack_drop_a: assert property (fall_ending_ack and !tx_role |=> !sda_oe)
        else $error("acknowledge not released after slot");
    nack_release_a: assert property (fall_ending_ack and tx_role && !acked
        |=> state == st_done && master_nack ##1 !sda_oe)
        else $error("device kept driving after missing acknowledge");
    more_bytes_a: assert property (fall_ending_ack and tx_role && acked
        |=> state == st_data && tx_next)
        else $error("acknowledged read did not continue");
    bus_cond_a: assert property (stop_det |=> state == st_idle && stop_seen && !sda_oe)
        else $error("stop not honoured");

endmodule

// ### sim/i2c_master_model.sv
// bus master model: drives scl and pulls sda low, samples the sda wire
// assumes a pull-up on sda (scl is driven both ways) and a bench clk of 100 ns (scl period 800 ns)
`timescale 1ns/1ps
module i2c_master_model (
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      m_oe
);
    // ----------------------------------------
    // bus conditions
    // ----------------------------------------
    // scl stands still high outside frames
    initial begin
        scl  = 1'b1;
        m_oe = 1'b0;
    end
    task automatic start_cond(); // also used as repeated start
        @(posedge clk) m_oe <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        m_oe <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
    endtask
    task automatic stop_cond();
        @(posedge clk) m_oe <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        m_oe <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // ----------------------------------------
    // bits and bytes
    // ----------------------------------------
    // seen is low only if the wire was low at both samples of the high phase
    // four clk low, four clk high: the target needs at least four per phase
    task automatic bit_cyc(input logic low, output logic seen);
        logic s1;
        @(posedge clk) m_oe <= low;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        @(posedge clk) s1 = sda_wire;
        repeat (3) @(posedge clk);
        seen = s1 | sda_wire;
        scl <= 1'b0;
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic slot);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(!b[i], s); // msb first
        end
        bit_cyc(1'b0, slot); // released, extra pulse for the slot
    endtask
    task automatic rd_byte(input logic ack, output logic [7:0] b, output logic slot);
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b0, b[i]);
        end
        bit_cyc(ack, slot); // ack all but the last byte
    endtask
endmodule

// ### sim/i2c_target_ack_test.sv
// testbench for the i2c target acknowledge logic
// assumes the master model above; pulses are counted by monitors here
`timescale 1ns/1ps
module i2c_target_ack_test;
    import i2c_ack_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       tx_mode = 1'b0;
    logic       ack_enable = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic       scl, m_oe, sda_out, sda_oe, rx_valid, tx_next;
    logic       master_nack, start_seen, stop_seen, bus_busy;
    logic [7:0] rx_byte, rx_last;
    wire        sda_wire = !(sda_oe | m_oe);
    int         n_mismatch = 0;
    int         check_count = 0;
    int         n_start = 0, n_stop = 0, n_rx = 0, n_txn = 0, n_nack = 0;
    always #50 clk = ~clk;
    i2c_master_model u_master (.clk(clk), .sda_wire(sda_wire), .scl(scl), .m_oe(m_oe));
    i2c_target_ack u_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .tx_mode(tx_mode), .ack_enable(ack_enable),
        .tx_byte(tx_byte), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_next(tx_next),
        .master_nack(master_nack), .start_seen(start_seen), .stop_seen(stop_seen),
        .bus_busy(bus_busy));
    // ----------------------------------------
    // monitors and checking
    // ----------------------------------------
    // sampled mid-cycle so pulses are read settled, with no race against the tasks
    always @(negedge clk) begin
        if (start_seen === 1'b1) n_start++;
        if (stop_seen === 1'b1) n_stop++;
        if (tx_next === 1'b1) n_txn++;
        if (master_nack === 1'b1) n_nack++;
        if (rx_valid === 1'b1) begin
            n_rx++;
            rx_last = rx_byte;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("mismatches %0d, comparisons %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // three acked bytes, then one refused by ack_enable low
    task automatic write_scn();
        logic [7:0] d [3] = '{8'hA5, 8'h00, 8'hFF};
        logic       a;
        @(posedge clk) ack_enable <= 1'b1;
        u_master.start_cond();
        check(8'(n_start), 8'h01);
        check(bus_busy, 1'b1);
        foreach (d[i]) begin
            u_master.wr_byte(d[i], a);
            check(a, SDA_LOW);
            check(rx_last, d[i]);
            repeat (5) @(posedge clk);
            check(sda_oe, 1'b0);
        end
        @(posedge clk) ack_enable <= 1'b0;
        u_master.wr_byte(8'h5A, a);
        check(a, LINE_IDLE);
        check(8'(n_rx), 8'h04);
    endtask
    // repeated start, one acked read byte, one refused, then stop
    task automatic read_scn();
        logic [7:0] b;
        logic       s;
        @(posedge clk) tx_mode <= 1'b1;
        tx_byte <= 8'h96;
        u_master.start_cond();
        check(8'(n_start), 8'h02);
        repeat (8) @(posedge clk);
        tx_byte <= 8'h3C;
        u_master.rd_byte(1'b1, b, s);
        check(b, 8'h96);
        // the pulse follows the slot's falling scl by three clk: two of sync latency, one of register
        repeat (4) @(posedge clk);
        check(8'(n_txn), 8'h01);
        u_master.rd_byte(1'b0, b, s);
        check(b, 8'h3C);
        check(s, LINE_IDLE);
        repeat (8) @(posedge clk);
        check(8'(n_nack), 8'h01);
        check(sda_oe, 1'b0);
        u_master.stop_cond();
        check(8'(n_stop), 8'h01);
        check(bus_busy, 1'b0);
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check(sda_oe, 1'b0);
        check(sda_out, 1'b0);
        write_scn();
        read_scn();
        wrap_up();
    end
    // all waits are fixed counts; this only cuts a stuck simulator short
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
endmodule
